// [sbst_consts.svh]
// Constants of the boundary-scan test access port
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH
`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_BSR_W       109
`define SBST_OE_BIT      108
`define SBST_OP_EXTEST   3'h0
`define SBST_OP_IDCODE   3'h1
`define SBST_OP_SAMPLEZ  3'h2
`define SBST_OP_SAMPLE   3'h4
`define SBST_OP_BYPASS   3'h7
`define SBST_IR_CAPTURE  3'h1
`define SBST_REV_DEF     3'h5       // Arbitrary value
`define SBST_DEVTYPE_DEF 17'h00001  // Arbitrary value
`define SBST_MAKER_DEF   11'h001    // Arbitrary value
`endif

// [sbst_pkg.sv]
// Types of the boundary-scan test access port
package sbst_pkg;
  typedef enum logic [3:0] {
    SBST_RESET, SBST_IDLE, SBST_SEL_DR, SBST_CAP_DR, SBST_SHIFT_DR, SBST_EXIT1_DR,
    SBST_PAUSE_DR, SBST_EXIT2_DR, SBST_UPD_DR, SBST_SEL_IR, SBST_CAP_IR, SBST_SHIFT_IR,
    SBST_EXIT1_IR, SBST_PAUSE_IR, SBST_EXIT2_IR, SBST_UPD_IR
  } sbst_state_t;

  // Serial pins as seen after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_pins_t;
endpackage : sbst_pkg

// [sbst_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sbst_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  initial begin
    if (WIDTH < 1) $error("sbst_sync: WIDTH must be positive");
  end

  // Chain; output moves only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_out <= '0;
    end else if (ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : sbst_sync

// [sbst_tap.sv]
// Boundary-scan test access port of the memory device
`timescale 1ns/1ps
`include "sbst_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module sbst_tap #(
  parameter int         BSR_W   = `SBST_BSR_W,
  parameter logic [2:0] REV     = `SBST_REV_DEF,     // Arbitrary value
  parameter logic [16:0] DEVTYPE = `SBST_DEVTYPE_DEF, // Arbitrary value
  parameter logic [10:0] MAKER   = `SBST_MAKER_DEF    // Arbitrary value
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic [BSR_W-1:0] pin_ring,
  output logic                  tdo,
  output logic                  tdo_oe_n,
  output logic [BSR_W-1:0]      pin_drive,
  output logic                  pin_override,
  output logic                  mem_out_en,
  output logic [2:0]            cur_instr
);
  sbst_pkg::sbst_state_t state_reg;
  sbst_pkg::sbst_state_t state_next;
  sbst_pkg::sbst_pins_t  pins;
  logic [`SBST_IR_W-1:0]  ir_shift_reg;
  logic [`SBST_IR_W-1:0]  ir_reg;
  logic                   bypass_reg;
  logic [`SBST_ID_W-1:0]  id_reg;
  logic [BSR_W-1:0]       bsr_reg;
  logic [BSR_W-1:0]       preload_reg;
  logic                   tck_d_reg;
  logic                   rise;
  logic                   fall;
  logic                   serial_bit;
  logic                   in_tlr;
  logic                   in_cap_dr;
  logic                   in_shift_dr;
  logic                   in_upd_dr;
  logic                   in_shift_ir;
  logic                   sel_id;
  logic                   tck_step;
  logic                   tck_drop;
  logic                   shifting_reg;
  logic                   sel_bsr;
  logic [`SBST_ID_W-1:0]  id_word;

  initial begin
    if (BSR_W <= `SBST_OE_BIT) $error("sbst_tap: BSR_W too small for enable cell");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and test-clock edges
  sbst_sync #(.WIDTH(3)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .pin_in  ({tck, tms, tdi}),
    .pin_out (pins)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tck_d_reg <= 1'b0;
    end else if (ce) begin
      tck_d_reg <= pins.tck;
    end
  end

  assign rise = pins.tck & ~tck_d_reg;
  assign fall = ~pins.tck & tck_d_reg;

  // Fixed identification word
  assign id_word = {REV, DEVTYPE, MAKER, 1'b1};

  // Chain selected for boundary instructions
  assign sel_bsr = (ir_reg == `SBST_OP_EXTEST) || (ir_reg == `SBST_OP_SAMPLEZ)
                || (ir_reg == `SBST_OP_SAMPLE);

  // Identification word is selected only by its own code
  assign sel_id = (ir_reg == `SBST_OP_IDCODE);

  //////////////////////////////////////////////////////////////////////////////
  // Controller state decode, shared by the register processes; every user
  // acts only on a detected test clock edge, so a glitch here is harmless
  assign in_tlr      = (state_reg == sbst_pkg::SBST_RESET);
  assign in_cap_dr   = (state_reg == sbst_pkg::SBST_CAP_DR);
  assign in_shift_dr = (state_reg == sbst_pkg::SBST_SHIFT_DR);
  assign in_upd_dr   = (state_reg == sbst_pkg::SBST_UPD_DR);
  assign in_shift_ir = (state_reg == sbst_pkg::SBST_SHIFT_IR);

  // Test clock events, both frozen by the clock enable; an edge is seen about
  // four system clocks after the pin moves, so each level must last that long
  assign tck_step = ce & rise;
  assign tck_drop = ce & fall;

  //////////////////////////////////////////////////////////////////////////////
  // Controller
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sbst_pkg::SBST_RESET:     state_next = pins.tms ? sbst_pkg::SBST_RESET : sbst_pkg::SBST_IDLE;
      sbst_pkg::SBST_IDLE:      state_next = pins.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_IDLE;
      sbst_pkg::SBST_SEL_DR:    state_next = pins.tms ? sbst_pkg::SBST_SEL_IR : sbst_pkg::SBST_CAP_DR;
      sbst_pkg::SBST_CAP_DR:    state_next = pins.tms ? sbst_pkg::SBST_EXIT1_DR
                                                      : sbst_pkg::SBST_SHIFT_DR;
      sbst_pkg::SBST_SHIFT_DR:  state_next = pins.tms ? sbst_pkg::SBST_EXIT1_DR
                                                      : sbst_pkg::SBST_SHIFT_DR;
      sbst_pkg::SBST_EXIT1_DR:  state_next = pins.tms ? sbst_pkg::SBST_UPD_DR
                                                      : sbst_pkg::SBST_PAUSE_DR;
      sbst_pkg::SBST_PAUSE_DR:  state_next = pins.tms ? sbst_pkg::SBST_EXIT2_DR
                                                      : sbst_pkg::SBST_PAUSE_DR;
      sbst_pkg::SBST_EXIT2_DR:  state_next = pins.tms ? sbst_pkg::SBST_UPD_DR
                                                      : sbst_pkg::SBST_SHIFT_DR;
      sbst_pkg::SBST_UPD_DR:    state_next = pins.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_IDLE;
      sbst_pkg::SBST_SEL_IR:    state_next = pins.tms ? sbst_pkg::SBST_RESET : sbst_pkg::SBST_CAP_IR;
      sbst_pkg::SBST_CAP_IR:    state_next = pins.tms ? sbst_pkg::SBST_EXIT1_IR
                                                      : sbst_pkg::SBST_SHIFT_IR;
      sbst_pkg::SBST_SHIFT_IR:  state_next = pins.tms ? sbst_pkg::SBST_EXIT1_IR
                                                      : sbst_pkg::SBST_SHIFT_IR;
      sbst_pkg::SBST_EXIT1_IR:  state_next = pins.tms ? sbst_pkg::SBST_UPD_IR
                                                      : sbst_pkg::SBST_PAUSE_IR;
      sbst_pkg::SBST_PAUSE_IR:  state_next = pins.tms ? sbst_pkg::SBST_EXIT2_IR
                                                      : sbst_pkg::SBST_PAUSE_IR;
      sbst_pkg::SBST_EXIT2_IR:  state_next = pins.tms ? sbst_pkg::SBST_UPD_IR
                                                      : sbst_pkg::SBST_SHIFT_IR;
      sbst_pkg::SBST_UPD_IR:    state_next = pins.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_IDLE;
      default:                  state_next = sbst_pkg::SBST_RESET;
    endcase
  end

  // State advances on rising test clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= sbst_pkg::SBST_RESET;
    end else if (ce && rise) begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ir_shift_reg <= `SBST_OP_IDCODE;
      ir_reg       <= `SBST_OP_IDCODE;
    end else if (ce && rise) begin
      case (state_reg)
        sbst_pkg::SBST_RESET: begin
          ir_reg <= `SBST_OP_IDCODE;
        end
        sbst_pkg::SBST_CAP_IR: begin
          ir_shift_reg <= `SBST_IR_CAPTURE;
        end
        sbst_pkg::SBST_SHIFT_IR: begin
          ir_shift_reg <= {pins.tdi, ir_shift_reg[`SBST_IR_W-1:1]};
        end
        sbst_pkg::SBST_UPD_IR: begin
          ir_reg <= ir_shift_reg;
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data registers: each captures in Capture-DR and shifts toward the serial
  // output, lowest bit first; the ID and pin chains move only under their codes, bypass always

  // Bypass cell: cleared in capture, follows serial input while shifting
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bypass_reg <= 1'b0;
    end else if (tck_step) begin
      if (in_cap_dr) begin
        bypass_reg <= 1'b0;
      end else if (in_shift_dr) begin
        bypass_reg <= pins.tdi;
      end
    end
  end

  // Identification register: loads the fixed word, then shifts it out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      id_reg <= '0;
    end else if (tck_step && sel_id) begin
      if (in_cap_dr) begin
        id_reg <= id_word;
      end else if (in_shift_dr) begin
        id_reg <= {pins.tdi, id_reg[`SBST_ID_W-1:1]};
      end
    end
  end

  // Pin chain: snapshot of the pin ring, then a serial path whose top bit
  // takes the serial input
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bsr_reg <= '0;
    end else if (tck_step && sel_bsr) begin
      if (in_cap_dr) begin
        bsr_reg <= pin_ring;
      end else if (in_shift_dr) begin
        bsr_reg <= {pins.tdi, bsr_reg[BSR_W-1:1]};
      end
    end
  end

  // Update latches; enable cell presets to one on test reset, so that a later
  // all-zero code starts with the memory outputs driving
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preload_reg               <= '0;
      preload_reg[`SBST_OE_BIT] <= 1'b1;
    end else if (tck_step) begin
      if (in_tlr) begin
        preload_reg[`SBST_OE_BIT] <= 1'b1;
      end else if (in_upd_dr && sel_bsr) begin
        preload_reg <= bsr_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit offered to the serial output; reserved codes fall back to bypass
  always_comb begin
    serial_bit = bypass_reg;
    if (in_shift_ir) begin
      serial_bit = ir_shift_reg[0];
    end else if (sel_bsr) begin
      serial_bit = bsr_reg[0];
    end else if (sel_id) begin
      serial_bit = id_reg[0];
    end
  end

  // Output enable tracks the state entered: low for a whole shift phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shifting_reg <= 1'b0;
    end else if (tck_step) begin
      shifting_reg <= (state_next == sbst_pkg::SBST_SHIFT_DR)
                   || (state_next == sbst_pkg::SBST_SHIFT_IR);
    end
  end

  // Registered pins; serial output moves on falling test clock only, so the
  // tester finds a settled bit at its next rising edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_drop) begin
      tdo_oe_n <= ~shifting_reg;
      if (in_shift_ir || in_shift_dr) begin
        tdo <= serial_bit;
      end
    end
  end

  // Memory side controls
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_drive    <= '0;
      pin_override <= 1'b0;
      mem_out_en   <= 1'b1;
      cur_instr    <= `SBST_OP_IDCODE;
    end else if (ce) begin
      cur_instr    <= ir_reg;
      pin_drive    <= preload_reg;
      pin_override <= (ir_reg == `SBST_OP_EXTEST);
      case (ir_reg)
        `SBST_OP_SAMPLEZ: mem_out_en <= 1'b0;
        `SBST_OP_EXTEST:  mem_out_en <= preload_reg[`SBST_OE_BIT];
        default:          mem_out_en <= 1'b1;
      endcase
    end
  end
endmodule : sbst_tap

// [sbst_tap_chk.sv]
// Assertion checker for the boundary-scan test port
`timescale 1ns/1ps
`include "sbst_consts.svh"
module sbst_tap_chk #(
  parameter int BSR_W = `SBST_BSR_W
) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             tck,
  input wire logic             tdo,
  input wire logic             tdo_oe_n,
  input wire logic [BSR_W-1:0] pin_drive,
  input wire logic             pin_override,
  input wire logic             mem_out_en,
  input wire logic [2:0]       cur_instr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Serial output moves only while the test clock is low
  a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 3))
    else $error("tdo moved after a rising test clock");
  // Leaving reset shows the identification code and enabled outputs
  a_reset_state: assert property ($fell(rst) |-> cur_instr == `SBST_OP_IDCODE
    && mem_out_en && !pin_override && tdo_oe_n) else $error("bad state after reset");
  // Floated sample keeps memory outputs off
  a_samplez_float: assert property ($past(cur_instr, 2) == `SBST_OP_SAMPLEZ
    && cur_instr == `SBST_OP_SAMPLEZ |-> !mem_out_en) else $error("outputs not floated");
  // Non-intrusive codes leave memory outputs on
  a_mem_enabled: assert property ($past(cur_instr, 2) == cur_instr
    && cur_instr inside {`SBST_OP_IDCODE, `SBST_OP_SAMPLE, `SBST_OP_BYPASS} |-> mem_out_en)
    else $error("memory outputs disturbed");
  // Pin drive override only under the all-zero code
  a_extest_override: assert property ($past(cur_instr, 2) == cur_instr
    |-> pin_override == (cur_instr == `SBST_OP_EXTEST)) else $error("override wrong");
  // Under the all-zero code the enable cell steers the outputs
  a_extest_oe_cell: assert property ($past(cur_instr, 2) == `SBST_OP_EXTEST
    && cur_instr == `SBST_OP_EXTEST && pin_drive == $past(pin_drive, 2)
    |-> mem_out_en == pin_drive[`SBST_OE_BIT]) else $error("enable cell ignored");
  // A new code lands only outside shifting
  a_instr_update: assert property ($changed(cur_instr) |-> tdo_oe_n && $past(tdo_oe_n))
    else $error("instruction changed while shifting");
  // Preloaded cells hold while shifting
  a_drive_hold: assert property (!tdo_oe_n |-> $stable(pin_drive))
    else $error("pin drive moved while shifting");
  c_shift: cover property ($fell(tdo_oe_n));
  c_samplez: cover property (cur_instr == `SBST_OP_SAMPLEZ && !mem_out_en);
  c_extest_on: cover property (pin_override && mem_out_en);
endmodule : sbst_tap_chk

// [sbst_tester.sv]
// Model of the board tester that works the serial test port
`timescale 1ns/1ps
module sbst_tester (
  input  wire logic sys_clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  // Idle pins before the first period
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock period of 400 ns: inputs change while low, output taken while high
  task automatic tick(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b1;
    repeat (2) @(posedge sys_clk);
    q = tdo;
    repeat (2) @(posedge sys_clk);
  endtask : tick
  // Idle to capture, shift n bits, update and back to idle
  task automatic scan(input logic ir, input int n, input logic [108:0] din,
                      output logic [108:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, ~tdi, q);
    if (ir) tick(1'b1, ~tdi, q);
    tick(1'b0, ~tdi, q);
    tick(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, ~tdi, q);
    tick(1'b0, ~tdi, q);
    // Let the last rising edge and the update reach the registered outputs
    repeat (4) @(posedge sys_clk);
  endtask : scan
  // Five mode-select highs reach the reset state, then idle
  task automatic reset_port();
    logic q;
    repeat (5) tick(1'b1, ~tdi, q);
    tick(1'b0, ~tdi, q);
  endtask : reset_port
endmodule : sbst_tester

// [test_sbst_tap.sv]
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "sbst_consts.svh"
module test_sbst_tap;
  localparam int W = `SBST_BSR_W;
  localparam logic [W-1:0] RING = {1'b1, {27{4'h6}}};
  localparam logic [W-1:0] PRE  = {1'b0, {27{4'h9}}};
  localparam logic [31:0]  ID_EXP = {`SBST_REV_DEF, `SBST_DEVTYPE_DEF, `SBST_MAKER_DEF, 1'b1};
  logic         sys_clk;
  logic         rst;
  logic         ce;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic [W-1:0] pin_ring;
  logic         tdo;
  logic         tdo_oe_n;
  logic [W-1:0] pin_drive;
  logic         pin_override;
  logic         mem_out_en;
  logic [2:0]   cur_instr;
  logic [W-1:0] got;
  int           err_count;
  int           n_tests;
  sbst_tap i_sbst_tap (.sys_clk, .rst, .ce, .tck, .tms, .tdi, .pin_ring, .tdo, .tdo_oe_n,
                       .pin_drive, .pin_override, .mem_out_en, .cur_instr);
  sbst_tester i_sbst_tester (.sys_clk, .tdo, .tck, .tms, .tdi);
  // Clock of 50 ns
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check
  // Load a code and see the capture pattern and the new instruction
  task automatic load(input logic [2:0] op);
    i_sbst_tester.scan(1'b1, 3, W'(op), got);
    @(posedge sys_clk);
    check(W'(got[1:0]), W'(2'b01), "instruction capture");
    check(W'(cur_instr), W'(op), "current instruction");
  endtask : load
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Watchdog
  initial begin
    repeat (10000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
  // Main sequence; only defined codes are loaded
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    pin_ring = RING;
    err_count = 0;
    n_tests = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(W'(cur_instr), W'(`SBST_OP_IDCODE), "reset instruction");
    // The port leaves reset in Test-Logic-Reset; walk it to idle first
    i_sbst_tester.reset_port();
    i_sbst_tester.scan(1'b0, 32, '0, got);
    check(W'(got[31:0]), W'(ID_EXP), "identification word");
    load(`SBST_OP_BYPASS);
    i_sbst_tester.scan(1'b0, 4, W'(4'hb), got);
    check(W'(got[3:0]), W'(4'h6), "bypass path");
    load(`SBST_OP_SAMPLE);
    i_sbst_tester.scan(1'b0, W, PRE, got);
    check(got, RING, "sample capture");
    check(pin_drive, PRE, "preload");
    load(`SBST_OP_SAMPLEZ);
    check(W'(mem_out_en), W'(1'b0), "floated outputs");
    i_sbst_tester.scan(1'b0, W, PRE, got);
    check(got, RING, "floated sample capture");
    load(`SBST_OP_EXTEST);
    check(W'({pin_override, mem_out_en}), W'(2'b10), "cell zero floats");
    i_sbst_tester.reset_port();
    @(posedge sys_clk);
    check(W'({cur_instr, mem_out_en}), W'(4'h3), "port reset");
    load(`SBST_OP_EXTEST);
    check(W'(mem_out_en), W'(1'b1), "enable cell preset");
    i_sbst_tester.scan(1'b0, W, PRE, got);
    check(got, RING, "extest capture");
    give_verdict();
  end
endmodule : test_sbst_tap
bind sbst_tap sbst_tap_chk #(.BSR_W(BSR_W)) i_sbst_tap_chk (.sys_clk, .rst, .tck, .tdo,
  .tdo_oe_n, .pin_drive, .pin_override, .mem_out_en, .cur_instr);
